// ---- verilog/ucrd_consts.vh ----
// Offsets, bank values and field positions of the channel register decoder
`ifndef UCRD_CONSTS_VH
`define UCRD_CONSTS_VH
`define UCRD_OFS_HOLD      4'h0
`define UCRD_OFS_IEN       4'h1
`define UCRD_OFS_ISTS      4'h2
`define UCRD_OFS_LCTL      4'h3
`define UCRD_OFS_MCTL      4'h4
`define UCRD_OFS_LSTS      4'h5
`define UCRD_OFS_MSTS      4'h6
`define UCRD_OFS_SCR       4'h7
`define UCRD_OFS_TXLV      4'h8
`define UCRD_OFS_RXLV      4'h9
`define UCRD_OFS_GDIR      4'ha
`define UCRD_OFS_GST       4'hb
`define UCRD_OFS_GIE       4'hc
`define UCRD_OFS_RSVD      4'hd
`define UCRD_OFS_GCTL      4'he
`define UCRD_OFS_XFC       4'hf
`define UCRD_LCTL_ENH_VAL  8'hbf
`define UCRD_LCTL_DIV_BIT  7
`define UCRD_EFN_ENH_BIT   4
`define UCRD_MCTL_LVL_BIT  2
`define UCRD_IEN_BASE_MASK 8'h0f
`define UCRD_MCTL_BASE_MASK 8'h1f
`define UCRD_FULL_MASK     8'hff
`define UCRD_RST_BYTE      8'h00
`define UCRD_RST_LCTL      8'h1d
`endif

// ---- verilog/ucrd_decoder.v ----
// Register map and bank decoder of one serial channel
`include "ucrd_consts.vh"
module ucrd_decoder (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Host access port
  input  wire [3:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Status from the channel datapath
  input  wire [7:0] rx_holding,
  input  wire [7:0] int_status,
  input  wire [7:0] line_status,
  input  wire [7:0] modem_status,
  input  wire [7:0] tx_fifo_fill,
  input  wire [7:0] rx_fifo_fill,
  input  wire [7:0] gpio_pin_in,
  // Strobes to the channel datapath
  output reg        tx_holding_wr,
  output reg  [7:0] tx_holding,
  output reg        fifo_control_wr,
  output reg  [7:0] fifo_control,
  output reg        rx_holding_rd,
  output reg        int_status_rd,
  output reg        line_status_rd,
  output reg        modem_status_rd,
  // Register contents to the channel datapath
  output wire [7:0] baud_div_low,
  output wire [7:0] baud_div_high,
  output wire [7:0] baud_div_frac,
  output wire [7:0] int_enable,
  output wire [7:0] enhanced_function,
  output wire [7:0] line_control,
  output wire [7:0] modem_control,
  output wire [7:0] flow_start_char1,
  output wire [7:0] flow_start_char2,
  output wire [7:0] flow_stop_char1,
  output wire [7:0] flow_stop_char2,
  output wire [7:0] halt_resume_levels,
  output wire [7:0] trigger_levels,
  output wire [7:0] scratch_pad,
  output wire [7:0] gpio_direction,
  output wire [7:0] gpio_pin_state,
  output wire [7:0] gpio_int_enable,
  output wire [7:0] gpio_control,
  output wire [7:0] extra_features_control
);

  // ==========================================================
  // Helpers
  // Divisor latch select bit of a line control value
  function div_latch;
    input [7:0] lc;
    begin
      div_latch = lc[`UCRD_LCTL_DIV_BIT];
    end
  endfunction

  // Passes the full byte when enhanced functions are on, else the base bits
  function [7:0] enh_gate;
    input [7:0] val;
    input [7:0] base;
    input       on;
    begin
      if (on)
        enh_gate = val & `UCRD_FULL_MASK;
      else
        enh_gate = val & base;
    end
  endfunction

  // ==========================================================
  // Storage
  reg [7:0] div_lo_q;
  reg [7:0] div_hi_q;
  reg [7:0] div_frac_q;
  reg [7:0] int_en_q;
  reg [7:0] enh_fn_q;
  reg [7:0] line_ctl_q;
  reg [7:0] modem_ctl_q;
  reg [7:0] xon1_q;
  reg [7:0] xon2_q;
  reg [7:0] xoff1_q;
  reg [7:0] xoff2_q;
  reg [7:0] halt_lvl_q;
  reg [7:0] trig_lvl_q;
  reg [7:0] scratch_q;
  reg [7:0] gdir_q;
  reg [7:0] gst_q;
  reg [7:0] gie_q;
  reg [7:0] gctl_q;
  reg [7:0] xfc_q;

  // ==========================================================
  // Bank selection
  wire       enh_bank;
  wire       div_sel;
  wire       div_bit;
  wire       enh_on;
  wire       lvl_sel;
  wire       rd_ok;

  assign enh_bank = (line_ctl_q == `UCRD_LCTL_ENH_VAL);
  assign div_bit  = div_latch(line_ctl_q);
  // Bank 0xbf has bit 7 set, so it must win over the divisor bank
  assign div_sel  = div_bit & ~enh_bank;
  assign enh_on   = enh_fn_q[`UCRD_EFN_ENH_BIT];
  // Offsets 6 and 7 show the level registers when both enable bits set, outside bank 0xbf
  assign lvl_sel  = enh_on & modem_ctl_q[`UCRD_MCTL_LVL_BIT];
  // A read that collides with a write is dropped
  assign rd_ok    = reg_rd & ~reg_wr;

  // ==========================================================
  // Write decode
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_lo_q    <= `UCRD_RST_BYTE;
      div_hi_q    <= `UCRD_RST_BYTE;
      div_frac_q  <= `UCRD_RST_BYTE;
      int_en_q    <= `UCRD_RST_BYTE;
      enh_fn_q    <= `UCRD_RST_BYTE;
      line_ctl_q  <= `UCRD_RST_LCTL;
      modem_ctl_q <= `UCRD_RST_BYTE;
      xon1_q  <= `UCRD_RST_BYTE;
      xon2_q  <= `UCRD_RST_BYTE;
      xoff1_q <= `UCRD_RST_BYTE;
      xoff2_q <= `UCRD_RST_BYTE;
      halt_lvl_q <= `UCRD_RST_BYTE;
      trig_lvl_q <= `UCRD_RST_BYTE;
      scratch_q  <= `UCRD_RST_BYTE;
      gdir_q  <= `UCRD_RST_BYTE;
      gst_q   <= `UCRD_RST_BYTE;
      gie_q   <= `UCRD_RST_BYTE;
      gctl_q  <= `UCRD_RST_BYTE;
      xfc_q   <= `UCRD_RST_BYTE;
      tx_holding_wr   <= 1'b0;
      tx_holding      <= `UCRD_RST_BYTE;
      fifo_control_wr <= 1'b0;
      fifo_control    <= `UCRD_RST_BYTE;
    end else begin
      tx_holding_wr   <= 1'b0;
      fifo_control_wr <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `UCRD_OFS_HOLD: begin
            if (div_sel) begin
              div_lo_q <= reg_wdata;
            end else if (!div_bit) begin
              tx_holding_wr <= 1'b1;
              tx_holding    <= reg_wdata;
            end
          end
          `UCRD_OFS_IEN: begin
            if (div_sel) begin
              div_hi_q <= reg_wdata;
            end else begin
              int_en_q <= reg_wdata;
            end
          end
          `UCRD_OFS_ISTS: begin
            if (enh_bank) begin
              enh_fn_q <= reg_wdata;
            end else if (div_sel) begin
              // Fraction divisor is hidden until enhanced functions are on
              if (enh_on)
                div_frac_q <= reg_wdata;
            end else begin
              fifo_control_wr <= 1'b1;
              fifo_control    <= reg_wdata;
            end
          end
          `UCRD_OFS_LCTL: begin
            line_ctl_q <= reg_wdata;
          end
          `UCRD_OFS_MCTL: begin
            if (enh_bank) begin
              xon1_q <= reg_wdata;
            end else begin
              modem_ctl_q <= reg_wdata;
            end
          end
          `UCRD_OFS_LSTS: begin
            // Line status is read only outside bank 0xbf
            if (enh_bank)
              xon2_q <= reg_wdata;
          end
          `UCRD_OFS_MSTS: begin
            if (enh_bank) begin
              xoff1_q <= reg_wdata;
            end else if (lvl_sel) begin
              halt_lvl_q <= reg_wdata;
            end
          end
          `UCRD_OFS_SCR: begin
            if (enh_bank) begin
              xoff2_q <= reg_wdata;
            end else if (lvl_sel) begin
              trig_lvl_q <= reg_wdata;
            end else begin
              scratch_q <= reg_wdata;
            end
          end
          `UCRD_OFS_GDIR: gdir_q <= reg_wdata;
          `UCRD_OFS_GST: begin
            if (!div_bit)
              gst_q <= reg_wdata;
          end
          `UCRD_OFS_GIE:  gie_q  <= reg_wdata;
          `UCRD_OFS_GCTL: gctl_q <= reg_wdata;
          `UCRD_OFS_XFC:  xfc_q  <= reg_wdata;
          // Fill counts and reserved slot ignore writes
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Read decode
  reg [7:0] rd_d;
  reg       rx_rd_d;
  reg       ists_rd_d;
  reg       lsts_rd_d;
  reg       msts_rd_d;
  always @* begin
    rd_d      = 8'h00;
    rx_rd_d   = 1'b0;
    ists_rd_d = 1'b0;
    lsts_rd_d = 1'b0;
    msts_rd_d = 1'b0;
    case (reg_addr)
      `UCRD_OFS_HOLD: begin
        if (div_sel) begin
          rd_d = div_lo_q;
        end else if (!div_bit) begin
          rd_d    = rx_holding;
          rx_rd_d = 1'b1;
        end
      end
      `UCRD_OFS_IEN: begin
        if (div_sel) begin
          rd_d = div_hi_q;
        end else begin
          rd_d = enh_gate(int_en_q, `UCRD_IEN_BASE_MASK, enh_on);
        end
      end
      `UCRD_OFS_ISTS: begin
        if (enh_bank) begin
          rd_d = enh_fn_q;
        end else if (div_sel) begin
          if (enh_on)
            rd_d = div_frac_q;
        end else begin
          rd_d      = int_status;
          ists_rd_d = 1'b1;
        end
      end
      `UCRD_OFS_LCTL: begin
        rd_d = line_ctl_q;
      end
      `UCRD_OFS_MCTL: begin
        if (enh_bank) begin
          rd_d = xon1_q;
        end else begin
          rd_d = modem_ctl_q;
        end
      end
      `UCRD_OFS_LSTS: begin
        if (enh_bank) begin
          rd_d = xon2_q;
        end else begin
          rd_d      = line_status;
          lsts_rd_d = 1'b1;
        end
      end
      `UCRD_OFS_MSTS: begin
        if (enh_bank) begin
          rd_d = xoff1_q;
        end else if (lvl_sel) begin
          rd_d = halt_lvl_q;
        end else begin
          rd_d      = modem_status;
          msts_rd_d = 1'b1;
        end
      end
      `UCRD_OFS_SCR: begin
        if (enh_bank) begin
          rd_d = xoff2_q;
        end else if (lvl_sel) begin
          rd_d = trig_lvl_q;
        end else begin
          rd_d = scratch_q;
        end
      end
      `UCRD_OFS_TXLV: rd_d = tx_fifo_fill;
      `UCRD_OFS_RXLV: rd_d = rx_fifo_fill;
      `UCRD_OFS_GDIR: rd_d = gdir_q;
      `UCRD_OFS_GST: begin
        // Input pins show their level, output pins the written value
        if (!div_bit)
          rd_d = (gpio_pin_in & ~gdir_q) | (gst_q & gdir_q);
      end
      `UCRD_OFS_GIE:  rd_d = gie_q;
      `UCRD_OFS_GCTL: rd_d = gctl_q;
      `UCRD_OFS_XFC:  rd_d = xfc_q;
      default: rd_d = 8'h00;
    endcase
  end

  // Read data registered; side-effect strobes pulse one cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata       <= 8'h00;
      rx_holding_rd   <= 1'b0;
      int_status_rd   <= 1'b0;
      line_status_rd  <= 1'b0;
      modem_status_rd <= 1'b0;
    end else begin
      if (rd_ok)
        reg_rdata <= rd_d;
      rx_holding_rd   <= rd_ok & rx_rd_d;
      int_status_rd   <= rd_ok & ists_rd_d;
      line_status_rd  <= rd_ok & lsts_rd_d;
      modem_status_rd <= rd_ok & msts_rd_d;
    end
  end

  // ==========================================================
  // Register outputs
  // Enhanced bits stay stored but act as zero until enabled
  assign int_enable    = enh_gate(int_en_q, `UCRD_IEN_BASE_MASK, enh_on);
  assign modem_control = enh_gate(modem_ctl_q, `UCRD_MCTL_BASE_MASK,
                                  enh_on);
  assign baud_div_low       = div_lo_q;
  assign baud_div_high      = div_hi_q;
  assign baud_div_frac      = div_frac_q;
  assign enhanced_function  = enh_fn_q;
  assign line_control       = line_ctl_q;
  assign flow_start_char1   = xon1_q;
  assign flow_start_char2   = xon2_q;
  assign flow_stop_char1    = xoff1_q;
  assign flow_stop_char2    = xoff2_q;
  assign halt_resume_levels = halt_lvl_q;
  assign trigger_levels     = trig_lvl_q;
  assign scratch_pad        = scratch_q;
  assign gpio_direction     = gdir_q;
  assign gpio_pin_state     = gst_q;
  assign gpio_int_enable    = gie_q;
  assign gpio_control       = gctl_q;
  assign extra_features_control = xfc_q;

endmodule // ucrd_decoder

// ---- verification/ucrd_asserts.sv ----
// Port checker of the channel register decoder, bound to its top module
module ucrd_asserts (
  // Clock and reset
  input logic       clk_sys,
  input logic       rst_n,
  // Host access
  input logic [3:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  // Datapath side
  input logic [7:0] line_status,
  input logic [7:0] tx_fifo_fill,
  input logic       tx_holding_wr,
  input logic [7:0] tx_holding,
  input logic       fifo_control_wr,
  input logic       line_status_rd,
  input logic [7:0] int_enable,
  input logic [7:0] enhanced_function,
  input logic [7:0] line_control
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_tx_write: assert property (
    reg_wr && reg_addr == 4'h0 && !line_control[7]
    |=> tx_holding_wr && tx_holding == $past(reg_wdata))
    else $error("tx byte not passed on");
  a_tx_quiet: assert property (
    !(reg_wr && reg_addr == 4'h0 && !line_control[7]) |=> !tx_holding_wr)
    else $error("stray tx strobe");
  a_fifo_ctl: assert property (
    reg_wr && reg_addr == 4'h2 && !line_control[7] |=> fifo_control_wr)
    else $error("fifo control strobe missing");
  a_lcr_write: assert property (
    reg_wr && reg_addr == 4'h3 |=> line_control == $past(reg_wdata))
    else $error("line control not written");
  a_status_read: assert property (
    reg_rd && !reg_wr && reg_addr == 4'h5 && line_control != 8'hbf
    |=> line_status_rd && reg_rdata == $past(line_status))
    else $error("line status read wrong");
  a_fill_read: assert property (
    reg_rd && !reg_wr && reg_addr == 4'h8
    |=> reg_rdata == $past(tx_fifo_fill))
    else $error("tx fill read wrong");
  a_rsvd_read: assert property (
    reg_rd && !reg_wr && reg_addr == 4'hd |=> reg_rdata == 8'h00)
    else $error("reserved slot not zero");
  a_enh_mask: assert property (
    !enhanced_function[4] |-> int_enable[7:4] == 4'h0)
    else $error("enhanced enables leak");
endmodule // ucrd_asserts

bind ucrd_decoder ucrd_asserts u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .line_status(line_status),
  .tx_fifo_fill(tx_fifo_fill), .tx_holding_wr(tx_holding_wr),
  .tx_holding(tx_holding), .fifo_control_wr(fifo_control_wr),
  .line_status_rd(line_status_rd), .int_enable(int_enable),
  .enhanced_function(enhanced_function), .line_control(line_control)
);

// ---- verification/ucrd_datapath_model.sv ----
// Fixed-level model of the channel datapath status lines
module ucrd_datapath_model (
  // Status toward the decoder
  output logic [7:0] rx_holding,
  output logic [7:0] int_status,
  output logic [7:0] line_status,
  output logic [7:0] modem_status,
  output logic [7:0] tx_fifo_fill,
  output logic [7:0] rx_fifo_fill,
  output logic [7:0] gpio_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Distinct values so a wrong source shows at once
  assign rx_holding   = 8'h5a;
  assign int_status   = 8'hc1;
  assign line_status  = 8'h60;
  assign modem_status = 8'hb0;
  assign tx_fifo_fill = 8'h40;
  assign rx_fifo_fill = 8'h03;
  assign gpio_pin_in  = 8'h96;
endmodule // ucrd_datapath_model

// ---- verification/ucrd_decoder_test.sv ----
// Self-checking bench of the channel register decoder
module ucrd_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, int_enable, rxh, ists, lsts, msts, txf, rxf, gin;
  logic [31:0] tbl [0:23];
  logic [31:0] r;
  int mismatches = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  ucrd_datapath_model u_dp (.rx_holding(rxh), .int_status(ists),
    .line_status(lsts), .modem_status(msts), .tx_fifo_fill(txf),
    .rx_fifo_fill(rxf), .gpio_pin_in(gin));
  ucrd_decoder uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_holding(rxh), .int_status(ists),
    .line_status(lsts), .modem_status(msts), .tx_fifo_fill(txf),
    .rx_fifo_fill(rxf), .gpio_pin_in(gin), .tx_holding_wr(),
    .tx_holding(), .fifo_control_wr(), .fifo_control(),
    .rx_holding_rd(), .int_status_rd(), .line_status_rd(),
    .modem_status_rd(), .baud_div_low(), .baud_div_high(),
    .baud_div_frac(), .int_enable(int_enable), .enhanced_function(),
    .line_control(), .modem_control(), .flow_start_char1(),
    .flow_start_char2(), .flow_stop_char1(), .flow_stop_char2(),
    .halt_resume_levels(), .trigger_levels(), .scratch_pad(),
    .gpio_direction(), .gpio_pin_state(), .gpio_int_enable(),
    .gpio_control(), .extra_features_control());
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  // ==========================================================
  // Main sequence: bank value, offset, write byte, expected read
  initial begin
    tbl[0] = 32'h0000a15a;
    tbl[1] = 32'h80001212;
    tbl[2] = 32'h80013434;
    tbl[3] = 32'h00010f0f;
    tbl[4] = 32'h000207c1;
    tbl[5] = 32'hbf021010;
    tbl[6] = 32'h80020909;
    tbl[7] = 32'hbf044141;
    tbl[8] = 32'hbf054242;
    tbl[9] = 32'hbf064343;
    tbl[10] = 32'hbf074444;
    tbl[11] = 32'h00031b1b;
    tbl[12] = 32'h00040303;
    tbl[13] = 32'h0005ff60;
    tbl[14] = 32'h0006ffb0;
    tbl[15] = 32'h00075c5c;
    tbl[16] = 32'h0008ff40;
    tbl[17] = 32'h0009ff03;
    tbl[18] = 32'h000af0f0;
    tbl[19] = 32'h000c5555;
    tbl[20] = 32'h000bfff6;
    tbl[21] = 32'h000dff00;
    tbl[22] = 32'h000e0505;
    tbl[23] = 32'h000f2121;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h3, 8'h1d);
    rd(4'h1, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      r = tbl[i];
      wr(4'h3, r[31:24]);
      wr(r[19:16], r[15:8]);
      rd(r[19:16], r[7:0]);
    end
    $display("table test done");
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h04);
    wr(4'h6, 8'h3c);
    rd(4'h6, 8'h3c);
    wr(4'h7, 8'ha5);
    rd(4'h7, 8'ha5);
    wr(4'h4, 8'h00);
    rd(4'h7, 8'h5c);
    rd(4'h6, 8'hb0);
    $display("bank test done");
    wr(4'h1, 8'hf3);
    rd(4'h1, 8'hf3);
    wr(4'h3, 8'hbf);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h80);
    rd(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    rd(4'h1, 8'h03);
    chk(int_enable, 8'h03);
    $display("enhance test done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h3, 8'h1d);
    rd(4'hf, 8'h00);
    $display("second reset test done");
    end_of_test();
  end
endmodule // ucrd_decoder_test
